//--- design/hfpr_pkg.sv
// Package of constants and types for the Hall fault protection supervisor
package hfpr_pkg;
    // ----------------------------------------
    // Timebase and blanking
    // ----------------------------------------
    localparam int unsigned CLK_HZ         = 50000000;
    localparam int unsigned TICK_NS        = 1000;
    localparam int unsigned TICK_CYCLES    = (TICK_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int unsigned BLANK_US       = 80;
    localparam int unsigned BLANK_TICKS    = BLANK_US * 1000 / TICK_NS;
    localparam int unsigned TICK_W         = 6;
    localparam int unsigned BLANK_W        = 8;
    localparam logic [TICK_W-1:0]  TICK_RST  = 6'h00;
    localparam logic [BLANK_W-1:0] BLANK_RST = 8'h00;
    localparam int unsigned NUM_CH         = 2;

    // ----------------------------------------
    // Channel states
    // ----------------------------------------
    typedef enum logic [1:0] {
        HFPR_OFF,
        HFPR_BLANK,
        HFPR_RUN,
        HFPR_GND_LATCH
    } hfpr_ch_state_t;
endpackage : hfpr_pkg

//--- design/hfpr_supervisor.sv
// Fault supervisor for two current-fed Hall sensor channels
// Functional notes
// - Supply out of 6V..18V: fault flag low, both channel currents off.
// - Supply back in range: both channels restart through blanking.
// - Channel current below 2mA (open): flag low, that channel off.
// - Open channel loaded again: restart with blanking, no host action.
// - Channel above supply rail: flag low, that channel off.
// - Channel current above 23mA (short to ground): flag low, channel off.
// - During short-to-ground shutdown, keep weak 50uA pull-up enabled.
// - Falling edge on select input restarts ground-latched channels with blanking.
// - Only short to ground latches; other faults clear themselves.
// - Supply out of range forces flag and both level outputs low.
`timescale 1ns/1ps
module hfpr_supervisor #(
    parameter int unsigned BLANK_TICKS_P = hfpr_pkg::BLANK_TICKS
) (
    input  wire logic       core_clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       supply_ok_in,
    input  wire logic [1:0] open_in,
    input  wire logic [1:0] short_supply_in,
    input  wire logic [1:0] short_ground_in,
    input  wire logic [1:0] hall_level_in,
    input  wire logic       fault_report_select_in,
    output logic      [1:0] channel_current_en_out,
    output logic      [1:0] pullup_en_out,
    output logic            fault_n_out,
    output logic            level_out_a_out,
    output logic            level_out_b_out
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        hfpr_pkg::hfpr_ch_state_t [1:0]   st;
        logic [1:0][hfpr_pkg::BLANK_W-1:0] blank;
        logic [hfpr_pkg::TICK_W-1:0]       tick_cnt;
        logic                              sel_prev;
        logic [1:0]                        cur_en;
        logic [1:0]                        pull_en;
        logic                              fault_n;
        logic [1:0]                        level;
    } hfpr_state_t;

    hfpr_state_t r;
    hfpr_state_t next_r;

    localparam logic [hfpr_pkg::BLANK_W-1:0] BLANK_LAST = hfpr_pkg::BLANK_W'(BLANK_TICKS_P - 1);
    localparam logic [hfpr_pkg::TICK_W-1:0]  TICK_LAST  = hfpr_pkg::TICK_W'(hfpr_pkg::TICK_CYCLES - 1);

    logic tick;
    logic sel_fall;
    assign tick     = (r.tick_cnt == TICK_LAST);
    assign sel_fall = r.sel_prev & ~fault_report_select_in;

    // ----------------------------------------
    // Decoding
    // ----------------------------------------
    // Sensor current flows in blanking and in normal running only
    function automatic logic ch_powered(input hfpr_pkg::hfpr_ch_state_t s);
        return (s == hfpr_pkg::HFPR_BLANK) || (s == hfpr_pkg::HFPR_RUN);
    endfunction : ch_powered

    function automatic logic ch_running(input hfpr_pkg::hfpr_ch_state_t s);
        return s == hfpr_pkg::HFPR_RUN;
    endfunction : ch_running

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic any_bad;
        any_bad = 1'b0;
        next_r = r;
        next_r.sel_prev = fault_report_select_in;
        next_r.tick_cnt = tick ? hfpr_pkg::TICK_RST : r.tick_cnt + 1'b1;
        for (int i = 0; i < hfpr_pkg::NUM_CH; i++) begin
            if (!supply_ok_in) begin
                // Supply fault dominates and also clears a ground latch
                next_r.st[i]    = hfpr_pkg::HFPR_OFF;
                next_r.blank[i] = hfpr_pkg::BLANK_RST;
            end else begin
                unique case (r.st[i])
                    hfpr_pkg::HFPR_OFF: begin
                        // Leaving off needs a clean open/short view; restart is automatic
                        if (!open_in[i] && !short_supply_in[i]) begin
                            next_r.st[i]    = hfpr_pkg::HFPR_BLANK;
                            next_r.blank[i] = hfpr_pkg::BLANK_RST;
                        end
                    end
                    hfpr_pkg::HFPR_BLANK, hfpr_pkg::HFPR_RUN: begin
                        if (short_ground_in[i]) begin
                            next_r.st[i] = hfpr_pkg::HFPR_GND_LATCH;
                        end else if (open_in[i] || short_supply_in[i]) begin
                            next_r.st[i] = hfpr_pkg::HFPR_OFF;
                        end else if (r.st[i] == hfpr_pkg::HFPR_BLANK && tick) begin
                            if (r.blank[i] == BLANK_LAST) begin
                                next_r.st[i] = hfpr_pkg::HFPR_RUN;
                            end else begin
                                next_r.blank[i] = r.blank[i] + 1'b1;
                            end
                        end
                    end
                    hfpr_pkg::HFPR_GND_LATCH: begin
                        // Open seen via pull-up releases the latch; it wins over a select edge so that
                        // an open line is never powered. A line above the rail is not restarted either.
                        if (open_in[i]) begin
                            next_r.st[i] = hfpr_pkg::HFPR_OFF;
                        end else if (sel_fall && !short_supply_in[i]) begin
                            next_r.st[i]    = hfpr_pkg::HFPR_BLANK;
                            next_r.blank[i] = hfpr_pkg::BLANK_RST;
                        end
                    end
                endcase
            end
            next_r.cur_en[i]  = ch_powered(next_r.st[i]);
            next_r.pull_en[i] = (next_r.st[i] == hfpr_pkg::HFPR_GND_LATCH);
            next_r.level[i]   = ch_running(next_r.st[i]) & hall_level_in[i];
            if (!ch_running(next_r.st[i])) begin
                any_bad = 1'b1;
            end
        end
        next_r.fault_n = ~any_bad;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            r.st[0]    <= hfpr_pkg::HFPR_OFF;
            r.st[1]    <= hfpr_pkg::HFPR_OFF;
            r.blank    <= {hfpr_pkg::BLANK_RST, hfpr_pkg::BLANK_RST};
            r.tick_cnt <= hfpr_pkg::TICK_RST;
            r.sel_prev <= 1'b0;
            r.cur_en   <= 2'h0;
            r.pull_en  <= 2'h0;
            r.fault_n  <= 1'b0;
            r.level    <= 2'h0;
        end else begin
            r <= next_r;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign channel_current_en_out = r.cur_en;
    assign pullup_en_out          = r.pull_en;
    assign fault_n_out            = r.fault_n;
    assign level_out_a_out        = r.level[0];
    assign level_out_b_out        = r.level[1];

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_supply_cuts_all: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !supply_ok_in |=> (channel_current_en_out == 2'h0 && !fault_n_out))
        else $error("supply fault did not cut both channels");
    a_supply_forces_low: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !supply_ok_in |=> (!level_out_a_out && !level_out_b_out))
        else $error("level outputs not forced low on supply fault");
    a_open_cuts_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (supply_ok_in && open_in[0]) |=> (!channel_current_en_out[0] && !fault_n_out))
        else $error("open channel a not cut");
    a_short_supply_cuts: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (supply_ok_in && short_supply_in[1] && !short_ground_in[1]) |=> !channel_current_en_out[1])
        else $error("short to supply on channel b not cut");
    a_gnd_pullup: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (supply_ok_in && channel_current_en_out[0] && short_ground_in[0]) |=> (pullup_en_out[0] && !fault_n_out))
        else $error("short to ground did not latch with pull-up");
    a_pullup_no_cur: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        pullup_en_out[0] |-> !channel_current_en_out[0])
        else $error("pull-up and current both on");
    a_sel_fall_restart: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (supply_ok_in && pullup_en_out[1] && !open_in[1] && !short_supply_in[1] && $fell(fault_report_select_in))
        |=> channel_current_en_out[1])
        else $error("select falling edge did not restart channel b");
    a_blank_holds_flag: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(channel_current_en_out[0]) |-> !fault_n_out[*2])
        else $error("flag high during blanking");
    a_auto_recover: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($fell(open_in[0]) && supply_ok_in && !short_supply_in[0] && !pullup_en_out[0]) |=> ##[0:2]
        channel_current_en_out[0])
        else $error("open channel a did not restart");
    a_open_cuts_b: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (supply_ok_in && open_in[1]) |=> (!channel_current_en_out[1] && !fault_n_out))
        else $error("open channel b not cut");
    a_latch_holds_b: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (supply_ok_in && pullup_en_out[1] && !open_in[1] && !$fell(fault_report_select_in)) |=> pullup_en_out[1])
        else $error("ground latch on channel b released without cause");
    a_supply_restart: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        ($rose(supply_ok_in) && open_in == 2'h0 && short_supply_in == 2'h0) |=>
        (channel_current_en_out == 2'h3 && !fault_n_out))
        else $error("channels not restarted into blanking after supply fault");
    a_blank_holds_b: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(channel_current_en_out[1]) |-> !fault_n_out[*2])
        else $error("flag high during blanking of channel b");
    a_flag_stays_high: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (fault_n_out && supply_ok_in && open_in == 2'h0 && short_supply_in == 2'h0 && short_ground_in == 2'h0)
        |=> fault_n_out)
        else $error("flag dropped with no fault present");
    a_level_follows: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (fault_n_out && supply_ok_in && open_in == 2'h0 && short_supply_in == 2'h0 && short_ground_in == 2'h0)
        |=> ({level_out_b_out, level_out_a_out} == $past(hall_level_in)))
        else $error("level outputs do not follow the running sensors");

    // ----------------------------------------
    // Covers
    // ----------------------------------------
    c_supply_recover: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        !supply_ok_in ##1 supply_ok_in ##[1:300] channel_current_en_out == 2'h3);
    c_reach_run: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        $rose(fault_n_out));
    c_gnd_restart: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        pullup_en_out[1] ##1 (!pullup_en_out[1] && channel_current_en_out[1]));
    c_manual_release: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
        pullup_en_out[0] ##1 (!pullup_en_out[0] && !channel_current_en_out[0]));
endmodule : hfpr_supervisor

//--- verification/hfpr_hall_model.sv
// Behavioural model of two two-wire Hall sensors on the current-fed lines
`timescale 1ns/1ps
module hfpr_hall_model (
    input  wire logic       core_clk_in,
    input  wire logic [3:0] fault_mode_in,
    input  wire logic [1:0] field_in,
    input  wire logic [1:0] channel_current_en_in,
    output logic      [1:0] open_out,
    output logic      [1:0] short_supply_out,
    output logic      [1:0] short_ground_out,
    output logic      [1:0] hall_level_out
);
    logic [1:0] idle_pattern = 2'h1;
    always_ff @(posedge core_clk_in) begin
        idle_pattern <= ~idle_pattern;
    end
    // Mode per channel: 0 loaded, 1 open, 2 short to supply, 3 short to ground
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            open_out[c]         = fault_mode_in[2*c+:2] == 2'h1;
            short_supply_out[c] = fault_mode_in[2*c+:2] == 2'h2;
            // A ground short only draws excess current while powered
            short_ground_out[c] = (fault_mode_in[2*c+:2] == 2'h3) && channel_current_en_in[c];
            // Unpowered sensor gives no valid level, so show a moving pattern
            hall_level_out[c]   = channel_current_en_in[c] ? field_in[c] : idle_pattern[c];
        end
    end
endmodule : hfpr_hall_model

//--- verification/hfpr_supervisor_tb.sv
// Self-checking testbench of the Hall fault supervisor
`timescale 1ns/1ps
module hfpr_supervisor_tb;
    logic core_clk_in, rst_n_in, supply_ok_in, fault_report_select_in, fault_n_out, level_out_a_out, level_out_b_out;
    logic [1:0] open_in, short_supply_in, short_ground_in, hall_level_in, channel_current_en_out, pullup_en_out;
    logic [1:0] field;
    logic [3:0] fault_mode;
    int mismatches = 0;
    int n_compared = 0;
    initial begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end
    hfpr_supervisor #(.BLANK_TICKS_P(2)) i_hfpr_supervisor (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
        .supply_ok_in(supply_ok_in), .open_in(open_in), .short_supply_in(short_supply_in),
        .short_ground_in(short_ground_in), .hall_level_in(hall_level_in),
        .fault_report_select_in(fault_report_select_in), .channel_current_en_out(channel_current_en_out),
        .pullup_en_out(pullup_en_out), .fault_n_out(fault_n_out), .level_out_a_out(level_out_a_out),
        .level_out_b_out(level_out_b_out));
    hfpr_hall_model i_hfpr_hall_model (.core_clk_in(core_clk_in), .fault_mode_in(fault_mode), .field_in(field),
        .channel_current_en_in(channel_current_en_out), .open_out(open_in), .short_supply_out(short_supply_in),
        .short_ground_out(short_ground_in), .hall_level_out(hall_level_in));
    task automatic cmp(input logic [1:0] got, input logic [1:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp
    task automatic cmp_flag(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : cmp_flag
    task automatic step(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask : step
    // Bounded wait for both channels to finish blanking: 2 ticks of 50 cycles plus margin
    task automatic wait_run();
        int k;
        for (k = 0; k < 400 && fault_n_out !== 1'b1; k++) step(1);
        cmp_flag(fault_n_out, 1'b1, "flag not released after blanking");
    endtask : wait_run
    task automatic t_supply();
        supply_ok_in = 1'b0;
        step(3);
        cmp(channel_current_en_out, 2'h0, "currents on with bad supply");
        cmp({level_out_b_out, level_out_a_out}, 2'h0, "levels not forced low");
        cmp_flag(fault_n_out, 1'b0, "flag not low with bad supply");
        supply_ok_in = 1'b1;
        step(3);
        cmp(channel_current_en_out, 2'h3, "no blanking restart");
        cmp_flag(fault_n_out, 1'b0, "flag high during supply restart blanking");
        wait_run();
    endtask : t_supply
    task automatic t_channel(input logic [3:0] mode, input logic [1:0] en_exp, input string what);
        fault_mode = mode;
        step(3);
        cmp(channel_current_en_out, en_exp, what);
        cmp_flag(fault_n_out, 1'b0, "flag not low on channel fault");
        cmp({level_out_b_out, level_out_a_out}, field & en_exp, "cut channel level not low");
        fault_mode = 4'h0;
        step(3);
        cmp(channel_current_en_out, 2'h3, "no self restart");
        cmp_flag(fault_n_out, 1'b0, "flag high before blanking ends");
        wait_run();
    endtask : t_channel
    task automatic t_ground();
        fault_mode = 4'hC;
        step(3);
        cmp(channel_current_en_out, 2'h1, "line b still powered");
        cmp(pullup_en_out, 2'h2, "weak pull-up missing");
        cmp_flag(level_out_b_out, 1'b0, "latched line level not low");
        fault_mode = 4'h0;
        step(20);
        cmp(channel_current_en_out, 2'h1, "ground latch lost");
        cmp_flag(fault_n_out, 1'b0, "flag high while latched");
        fault_report_select_in = 1'b1;
        step(2);
        cmp(pullup_en_out, 2'h2, "latch released on select rise");
        fault_report_select_in = 1'b0;
        step(3);
        cmp(pullup_en_out, 2'h0, "pull-up kept after select fall");
        cmp(channel_current_en_out, 2'h3, "no restart on select fall");
        wait_run();
    endtask : t_ground
    task automatic t_levels(input logic [1:0] f);
        field = f;
        step(3);
        cmp({level_out_b_out, level_out_a_out}, f, "levels not passed");
    endtask : t_levels
    // Manual re-energize: ground latch on line a, then open, then reconnect
    task automatic t_manual();
        fault_mode = 4'h3;
        step(3);
        cmp(pullup_en_out, 2'h1, "line a not ground-latched");
        fault_mode = 4'h1;
        step(3);
        cmp(pullup_en_out, 2'h0, "open did not release ground latch");
        cmp(channel_current_en_out, 2'h2, "open line a powered");
        fault_mode = 4'h0;
        step(3);
        cmp(channel_current_en_out, 2'h3, "reconnected line a not restarted");
        wait_run();
    endtask : t_manual
    // Reset in mid-run while line b is ground-latched
    task automatic t_reset();
        fault_mode = 4'hC;
        step(3);
        fault_mode = 4'h0;
        rst_n_in = 1'b0;
        step(2);
        cmp(pullup_en_out, 2'h0, "pull-up on in reset");
        cmp(channel_current_en_out, 2'h0, "currents on in reset");
        cmp({level_out_b_out, level_out_a_out}, 2'h0, "levels not low in reset");
        cmp_flag(fault_n_out, 1'b0, "flag high in reset");
        rst_n_in = 1'b1;
        step(1);
        cmp(channel_current_en_out, 2'h3, "no blanking start after reset");
        wait_run();
    endtask : t_reset
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    initial begin
        rst_n_in = 1'b0;
        supply_ok_in = 1'b1;
        fault_report_select_in = 1'b0;
        fault_mode = 4'h0;
        field = 2'h1;
        step(3);
        rst_n_in = 1'b1;
        wait_run();
        t_levels(2'h2);
        t_supply();
        t_channel(4'h1, 2'h2, "open line a not cut");
        t_channel(4'h4, 2'h1, "open line b not cut");
        t_channel(4'h2, 2'h2, "shorted line a not cut");
        t_channel(4'h8, 2'h1, "shorted line b not cut");
        t_ground();
        t_manual();
        t_reset();
        t_levels(2'h1);
        tally_and_finish();
    end
    // Whole run needs under two thousand cycles; allow ten thousand before declaring a hang
    initial begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule : hfpr_supervisor_tb
